/* File: hw/hspmc_ctrl.sv */
// halt / clock-stop power mode controller with apb control registers
// assumes cpu core and peripherals on the same clock; ce and port 0d are pins
//
// Behaviour
// - halt keeps peripherals running from settings
// - clock stop halts oscillator and all activity
// - clock stop reloads control registers to defaults
// - pc held at halt or stop instruction
// - system registers kept; peripherals partly reinitialised
// - timers, synthesizer, adc: halt run, stop off
// - pwm outputs stop, pins become plain outputs
// - serial master stops in halt, slave continues
// - frequency counter stops, pins become inputs
// - tone output stops, pins become port io
// - ports keep state, inputs, output latches
// - synthesizer disabled while chip enable low
// - stop forces port function except listed pins
// - bidirectional directions kept through clock stop
// - upper port 1a stay interrupt inputs
// - adc pins and pull-down enables kept
// - port 1b outputs drive last values
// - port 0d pull-downs software controlled
// - port 0d high level releases stop
// - stay halted tset/2 then resume
// - zero release operand: only reset ends stop
// - stop is nop on ce rise or counter
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`include "hspmc_map.svh"
module hspmc_ctrl (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clockEnable,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic chipEnablePin,
  input wire logic [3:0] analogInputPort,
  input wire logic wakeIrq,
  input wire logic enableResetCounterActiveFlag,
  input wire logic [15:0] haltPc,
  input wire logic spiExternalClock,
  output logic oscStop,
  output logic cpuHold,
  output logic [15:0] heldPc,
  output logic periphHalt,
  output logic periphStop,
  output logic ctrlRegReload,
  output logic timerRun,
  output logic synthRun,
  output logic adcRun,
  output logic pwmRun,
  output logic serialRun,
  output logic freqCountRun,
  output logic toneRun,
  output logic portForceGeneral,
  output logic portKeepDirection,
  output logic interruptInputPinHigh,
  output logic interruptInputPinLow,
  output logic analogAuxKeep,
  output logic [3:0] analogPullDownEn
);
  hspmc_pkg::hspmc_state_type state_r, state_nxt;
  logic [3:0] relSel_r, relSel_nxt;
  logic [3:0] pullDown_r, pullDown_nxt;
  logic [15:0] settle_r, settle_nxt;
  logic [15:0] count_r, count_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic ceMeta_r, ceSync_r, ceLast_r;
  logic [3:0] p0dMeta_r, p0dSync_r;
  logic extMeta_r, extSync_r;
  logic haltReq, stopReq, wr, rd, ceRise, releaseHit;

  // pins pass two flops before any logic reads them
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ceMeta_r <= 1'b0;
      ceSync_r <= 1'b0;
      ceLast_r <= 1'b0;
      p0dMeta_r <= 4'h0;
      p0dSync_r <= 4'h0;
      extMeta_r <= 1'b0;
      extSync_r <= 1'b0;
    end else if (clockEnable) begin
      ceMeta_r <= chipEnablePin;
      ceSync_r <= ceMeta_r;
      ceLast_r <= ceSync_r;
      p0dMeta_r <= analogInputPort;
      p0dSync_r <= p0dMeta_r;
      extMeta_r <= spiExternalClock;
      extSync_r <= extMeta_r;
    end
  end

  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign ceRise = ceSync_r && !ceLast_r;
  assign haltReq = wr && paddr == `HSPMC_REG_CTRL && pwdata[`HSPMC_CTRL_HALT_BIT];
  assign stopReq = wr && paddr == `HSPMC_REG_CTRL && pwdata[`HSPMC_CTRL_STOP_BIT];
  // zero operand selects no source, so only reset leaves stop
  assign releaseHit = (relSel_r[`HSPMC_REL_P0D] && |p0dSync_r)
    || (relSel_r[`HSPMC_REL_CE] && ceSync_r)
    || (relSel_r[`HSPMC_REL_WAKE] && wakeIrq);

  always_comb begin
    state_nxt = state_r;
    relSel_nxt = relSel_r;
    pullDown_nxt = pullDown_r;
    settle_nxt = settle_r;
    count_nxt = count_r;
    pc_nxt = pc_r;
    rdata_nxt = rdata_r;
    if (wr && paddr == `HSPMC_REG_PORT) begin
      pullDown_nxt = pwdata[`HSPMC_PORT_PD_LSB +: 4];
    end
    if (wr && paddr == `HSPMC_REG_SET) begin
      settle_nxt = pwdata[15:0];
    end
    case (state_r)
      hspmc_pkg::RUN: begin
        // stop ignored on ce rise or while ce reset counter runs
        if (stopReq && !ceRise && !enableResetCounterActiveFlag) begin
          state_nxt = hspmc_pkg::STOP;
          relSel_nxt = pwdata[`HSPMC_CTRL_REL_LSB +: 4];
          pc_nxt = haltPc;
        end else if (haltReq) begin
          state_nxt = hspmc_pkg::HALT;
          relSel_nxt = pwdata[`HSPMC_CTRL_REL_LSB +: 4];
          pc_nxt = haltPc;
        end
      end
      hspmc_pkg::HALT: begin
        if (releaseHit) begin
          state_nxt = hspmc_pkg::RUN;
        end
      end
      hspmc_pkg::STOP: begin
        if (releaseHit) begin
          state_nxt = hspmc_pkg::SETTLE;
          count_nxt = {1'b0, settle_r[15:1]}; // half the settle time
        end
      end
      hspmc_pkg::SETTLE: begin
        if (count_r <= 16'h0001) begin
          state_nxt = hspmc_pkg::RUN;
        end else begin
          count_nxt = count_r - 16'h0001;
        end
      end
      default: state_nxt = hspmc_pkg::RUN;
    endcase
    if (rd) begin
      case (paddr)
        `HSPMC_REG_CTRL: rdata_nxt = {24'h000000, relSel_r, 4'h0};
        `HSPMC_REG_STAT: rdata_nxt = {16'h0000, pc_r};
        `HSPMC_REG_PORT: rdata_nxt = {28'h0000000, pullDown_r};
        `HSPMC_REG_SET: rdata_nxt = {16'h0000, settle_r};
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= hspmc_pkg::RUN;
      relSel_r <= 4'h0;
      pullDown_r <= `HSPMC_PORT_PD_RST;
      settle_r <= `HSPMC_SETTLE_RST;
      count_r <= 16'h0000;
      pc_r <= 16'h0000;
      rdata_r <= 32'h00000000;
    end else if (clockEnable) begin
      state_r <= state_nxt;
      relSel_r <= relSel_nxt;
      pullDown_r <= pullDown_nxt; // kept across halt and stop
      settle_r <= settle_nxt;
      count_r <= count_nxt;
      pc_r <= pc_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  logic inStop, inHalt;
  assign inStop = state_r == hspmc_pkg::STOP;
  assign inHalt = state_r == hspmc_pkg::HALT || state_r == hspmc_pkg::SETTLE;
  assign prdata = rdata_r;
  assign oscStop = inStop;
  assign cpuHold = inStop || inHalt;
  assign heldPc = pc_r;
  assign periphHalt = inHalt;
  assign periphStop = inStop;
  // one-cycle reload pulse on stop entry; system registers untouched
  // gated by the enable so a frozen core never sees a reload without entry
  assign ctrlRegReload = clockEnable && state_r == hspmc_pkg::RUN && state_nxt == hspmc_pkg::STOP;
  assign timerRun = !inStop;
  assign synthRun = !inStop && ceSync_r;
  assign adcRun = !inStop;
  assign pwmRun = !inStop;
  // master stalls in halt since its own clock is gated
  assign serialRun = !inStop && (!inHalt || extSync_r);
  assign freqCountRun = !inStop;
  assign toneRun = !inStop;
  // force and direction overrides only while stopped, released on exit; interrupt and analog keeps always on
  assign portForceGeneral = inStop;
  assign portKeepDirection = inStop;
  assign interruptInputPinHigh = 1'b1;
  assign interruptInputPinLow = 1'b1;
  assign analogAuxKeep = 1'b1;
  assign analogPullDownEn = pullDown_r;
endmodule // hspmc_ctrl

/* File: hw/hspmc_map.svh */
// constants for the halt / clock-stop power mode controller
// assumes inclusion by bare name from the design
`ifndef HSPMC_MAP_SVH
`define HSPMC_MAP_SVH
`define HSPMC_REG_CTRL 12'h000
`define HSPMC_REG_STAT 12'h004
`define HSPMC_REG_PORT 12'h008
`define HSPMC_REG_SET 12'h00C
`define HSPMC_CTRL_HALT_BIT 0
`define HSPMC_CTRL_STOP_BIT 1
`define HSPMC_CTRL_REL_LSB 4
`define HSPMC_CTRL_SETTLE_LSB 8
`define HSPMC_PORT_PD_LSB 0
`define HSPMC_PORT_PD_RST 4'h0
`define HSPMC_SETTLE_RST 16'h0400
`define HSPMC_REL_P0D 0
`define HSPMC_REL_CE 1
`define HSPMC_REL_WAKE 2
`endif

/* File: hw/hspmc_pkg.sv */
// types for the halt / clock-stop power mode controller
// assumes hspmc_map.svh is on the include path
package hspmc_pkg;
  typedef enum logic [2:0] {
    RUN,
    HALT,
    STOP,
    SETTLE
  } hspmc_state_type;
endpackage

/* File: tb/hspmc_ctrl_sva.sv */
// checker for hspmc_ctrl run, hold and pin override outputs
// assumes a settle time of 8 cycles before any stop release
`timescale 1ns/1ps
module hspmc_ctrl_sva (
  input wire logic clock, arst_n, chipEnablePin, spiExternalClock, oscStop, cpuHold, ctrlRegReload,
  input wire logic periphHalt, periphStop, timerRun, adcRun, toneRun, serialRun, synthRun, portForceGeneral,
  input wire logic [15:0] haltPc, heldPc,
  input wire logic [3:0] analogPullDownEn
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);
  a_halt_runs: assert property (periphHalt |-> timerRun && adcRun && toneRun) else $error("unit idle in halt");
  a_stop_idle: assert property (oscStop |-> cpuHold && !timerRun && !adcRun && !toneRun) else $error("unit live");
  a_stop_reload: assert property ($rose(oscStop) |-> $past(ctrlRegReload)) else $error("no reload");
  a_pc_held: assert property ($rose(cpuHold) |-> heldPc == $past(haltPc)) else $error("held pc wrong");
  a_master_off: assert property (!spiExternalClock [*4] ##0 periphHalt |-> !serialRun) else $error("master on");
  a_synth_off: assert property (!chipEnablePin [*4] |-> !synthRun) else $error("synth on, ce low");
  a_port_force: assert property (oscStop |-> portForceGeneral) else $error("port not forced");
  a_pull_keep: assert property (oscStop |-> $stable(analogPullDownEn)) else $error("pull-down moved");
  a_settle_wait: assert property ($fell(oscStop) |-> cpuHold [*3] ##[1:4] !cpuHold) else $error("settle");
  a_mode_split: assert property (!(periphHalt && periphStop)) else $error("halt and stop together");
  cover property ($rose(periphHalt));
  cover property ($rose(oscStop));
  cover property ($fell(oscStop));
endmodule // hspmc_ctrl_sva
bind hspmc_ctrl hspmc_ctrl_sva chk (.*);

/* File: tb/hspmc_cpu_model.sv */
// cpu core model: program counter, wake and reset counter flags
// assumes bench requests change on rising edges
`timescale 1ns/1ps
module hspmc_cpu_model (
  input wire logic clock, arst_n, cpuHold, wakeReq, cntReq,
  output logic [15:0] haltPc,
  output logic wakeIrq, enableResetCounterActiveFlag
);
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      haltPc <= 16'h0100;
      wakeIrq <= 1'b0;
      enableResetCounterActiveFlag <= 1'b0;
    end else begin
      // pc frozen while held, so the held address is observable
      if (!cpuHold) haltPc <= haltPc + 16'h0001;
      wakeIrq <= wakeReq;
      enableResetCounterActiveFlag <= cntReq;
    end
  end
endmodule // hspmc_cpu_model

/* File: tb/halt_stop_power_mode_control_tb.sv */
// bench for hspmc_ctrl: apb access, halt, stop and release
// assumes cpu model on the far side; settle time set to 8
`timescale 1ns/1ps
module halt_stop_power_mode_control_tb;
  logic clock = 0, arst_n = 0, clockEnable = 1, psel = 0, penable = 0, pwrite = 0, chipEnablePin = 0;
  logic spiExternalClock = 0, wakeReq = 0, cntReq = 0, wakeIrq, enableResetCounterActiveFlag, pready, pslverr;
  logic oscStop, cpuHold, periphHalt, periphStop, ctrlRegReload, timerRun, synthRun, adcRun, pwmRun, serialRun;
  logic freqCountRun, toneRun, portForceGeneral, portKeepDirection, interruptInputPinHigh, interruptInputPinLow;
  logic analogAuxKeep;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic [15:0] haltPc, heldPc;
  logic [3:0] analogInputPort = 0, analogPullDownEn;
  logic [2:0] watch;
  int bad_count = 0, cmp_count = 0;
  assign watch = {cpuHold, oscStop, pready};
  hspmc_ctrl dut (.*);
  hspmc_cpu_model cpu (.*);
  initial forever #12.5 clock = ~clock;
  task summarize;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] s, e);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  // sample at the falling edge, return aligned to a rising edge
  task waitOn(input int s, input logic v);
    repeat (99) begin
      @(negedge clock);
      if (watch[s] === v) break;
    end
    if (watch[s] !== v) begin
      bad_count++;
      summarize;
    end else begin
      @(posedge clock);
    end
  endtask
  // read data is registered: valid one edge after the access edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    waitOn(0, 1);
    psel <= 0;
    penable <= 0;
    @(posedge clock);
  endtask
  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clock);
    arst_n <= 1;
    apb(0, 12'h00C, 0);
    chk("settle", prdata, 32'h400);
    apb(0, 12'h010, 0);
    chk("unmapped", prdata, 32'h0);
    apb(1, 12'h008, 32'h5);
    apb(0, 12'h008, 0);
    chk("pull-down", prdata, 32'h5);
    clockEnable <= 0;
    apb(1, 12'h008, 32'hA);
    clockEnable <= 1;
    apb(0, 12'h008, 0);
    chk("frozen write", prdata, 32'h5);
    apb(1, 12'h00C, 32'h8);
    chk("synth", synthRun, 32'h0);
    chipEnablePin <= 1;
    $display("registers done");
    apb(1, 12'h000, 32'h41);
    chk("halt", {periphHalt, timerRun, serialRun}, 32'h6);
    chk("synth on", synthRun, 32'h1);
    spiExternalClock <= 1;
    repeat (3) @(posedge clock);
    chk("slave runs", serialRun, 32'h1);
    spiExternalClock <= 0;
    wakeReq <= 1;
    waitOn(2, 0);
    wakeReq <= 0;
    $display("halt done");
    cntReq <= 1;
    apb(1, 12'h000, 32'h12);
    chk("refused", oscStop, 32'h0);
    cntReq <= 0;
    apb(1, 12'h000, 32'h12);
    chk("stop runs", {oscStop, timerRun, adcRun, pwmRun, freqCountRun, toneRun}, 32'h20);
    chk("stop pins", {portForceGeneral, portKeepDirection, interruptInputPinHigh, analogAuxKeep}, 32'hF);
    chk("stop pulls", analogPullDownEn, 32'h5);
    analogInputPort <= 4'h1;
    waitOn(1, 0);
    chk("settling", cpuHold, 32'h1);
    waitOn(2, 0);
    chk("awake", {portForceGeneral, adcRun}, 32'h1);
    analogInputPort <= 4'h0;
    $display("stop release done");
    apb(1, 12'h000, 32'h2);
    analogInputPort <= 4'hF;
    wakeReq <= 1;
    repeat (40) @(posedge clock);
    chk("no release", oscStop, 32'h1);
    arst_n <= 0;
    repeat (2) @(posedge clock);
    arst_n <= 1;
    @(posedge clock);
    chk("reset ends stop", oscStop, 32'h0);
    $display("zero operand done");
    summarize;
  end
endmodule // halt_stop_power_mode_control_tb
